// ### src/sltc_regs.vh
// Function
// - timestamp enable puts external timestamp into LSB of every output sample
// - timestamp path delay equals analog sample path delay
// - timestamp sits in lowest bit of N-bit field, converter bits intact
// - subsystem enable: 0 off, 1 on, resets to 1
// - enable low holds link in reset, serializers down, clocks gated
// - enable low holds multiframe counter in reset, sysref ignored
// - six-bit output-mode field in bits 5:0 selects link configuration
// - eight-bit field holds frames per multiframe minus one, reset 0x1F
// - 64b/66b modes ignore field, length is 256 times E over F
`ifndef SLTC_REGS_VH
`define SLTC_REGS_VH
// ---------------------------------------------------------------
// register offsets (byte addresses = 4 * index)
// ---------------------------------------------------------------
`define SLTC_IDX_TS_CTRL   12'h160
`define SLTC_IDX_SUB_EN    12'h200
`define SLTC_IDX_OUT_MODE  12'h201
`define SLTC_IDX_KM1       12'h202
`define SLTC_IDX_STATUS    12'h210
`define SLTC_IDX_E_PARAM   12'h211
// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define SLTC_TS_EN_BIT     0
`define SLTC_SUB_EN_BIT    0
`define SLTC_MODE_MSB      5
`define SLTC_RST_TS_CTRL   8'h00
`define SLTC_RST_SUB_EN    8'h01
`define SLTC_RST_OUT_MODE  8'h00
`define SLTC_RST_KM1       8'h1F
`define SLTC_RST_E_PARAM   8'h01
`define SLTC_K64_SCALE     16'h0100
`define SLTC_ILA_CS        2'h0
`endif

// ### src/sltc_link_tx_control.v
`timescale 1ns/10ps
`include "sltc_regs.vh"
// ---------------------------------------------------------------
// link transmit control register bank
// ---------------------------------------------------------------
module sltc_link_tx_control #(
    parameter N_BITS   = 16,
    parameter ADC_BITS = 9,
    parameter PIPE     = 2
) (
    // clock and reset
    input  wire                clk_sys_i,
    input  wire                rst_n_i,
    // avalon-mm slave
    input  wire [13:0]         avs_address_i,
    input  wire                avs_read_i,
    input  wire                avs_write_i,
    input  wire [31:0]         avs_writedata_i,
    input  wire [3:0]          avs_byteenable_i,
    output reg  [31:0]         avs_readdata_o,
    output reg                 avs_waitrequest_o,
    output reg  [1:0]          avs_response_o,
    // sample path
    input  wire [ADC_BITS-1:0] adc_sample_i,
    input  wire                timestamp_i,
    output reg  [N_BITS-1:0]   link_sample_o,
    // link control
    input  wire                sysref_i,
    output reg                 link_reset_n_o,
    output reg                 serializer_power_o,
    output reg                 link_clock_enable_o,
    output reg  [5:0]          link_output_mode_o,
    output reg  [1:0]          ila_control_bits_o,
    output reg  [8:0]          frames_per_multiframe_o,
    output reg  [8:0]          mf_count_o
);

    // registers
    reg [7:0]          timestamp_lsb_control;
    reg [7:0]          link_subsystem_enable;
    reg [7:0]          link_output_mode;
    reg [7:0]          multiframe_length_minus_one;
    reg [7:0]          e_param;
    reg                pending;
    reg [31:0]         next_rdata;
    reg                hit;
    reg [11:0]         idx;
    // synchronisers for pins
    reg                ts_s1, ts_s2, sr_s1, sr_s2, sr_d;
    reg [ADC_BITS-1:0] adc_s1, adc_s2;
    reg [PIPE-1:0]     ts_pipe;
    reg [ADC_BITS-1:0] adc_pipe [0:PIPE-1];
    wire               en  = link_subsystem_enable[`SLTC_SUB_EN_BIT];
    wire               m64 = link_output_mode[5];
    reg  [31:0]        k64_full;
    reg  [15:0]        k64;
    reg  [8:0]         k_eff;
    reg  [N_BITS-1:0]  smp;
    integer            i;

    // true for every index that answers with an ok response
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `SLTC_IDX_TS_CTRL) || (a == `SLTC_IDX_SUB_EN) ||
                        (a == `SLTC_IDX_OUT_MODE) || (a == `SLTC_IDX_KM1) ||
                        (a == `SLTC_IDX_STATUS) || (a == `SLTC_IDX_E_PARAM);
        end
    endfunction

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    always @* begin
        idx = avs_address_i[13:2];
        hit = is_mapped(idx);
        next_rdata = 32'h00000000;
        case (idx)
            `SLTC_IDX_TS_CTRL:  next_rdata = {24'h000000, timestamp_lsb_control};
            `SLTC_IDX_SUB_EN:   next_rdata = {24'h000000, link_subsystem_enable};
            `SLTC_IDX_OUT_MODE: next_rdata = {24'h000000, link_output_mode};
            `SLTC_IDX_KM1:      next_rdata = {24'h000000, multiframe_length_minus_one};
            `SLTC_IDX_STATUS:   next_rdata = {15'h0000, en, mf_count_o[7:0], k_eff[7:0]};
            `SLTC_IDX_E_PARAM:  next_rdata = {24'h000000, e_param};
            default:            next_rdata = 32'h00000000;
        endcase
    end

    // one wait cycle per access; write lands when waitrequest drops
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending                     <= 1'b0;
            avs_waitrequest_o           <= 1'b1;
            avs_readdata_o              <= 32'h00000000;
            avs_response_o              <= 2'h0;
            timestamp_lsb_control       <= `SLTC_RST_TS_CTRL;
            link_subsystem_enable       <= `SLTC_RST_SUB_EN;
            link_output_mode            <= `SLTC_RST_OUT_MODE;
            multiframe_length_minus_one <= `SLTC_RST_KM1;
            e_param                     <= `SLTC_RST_E_PARAM;
        end else begin
            avs_waitrequest_o <= 1'b1;
            pending           <= 1'b0;
            if ((avs_read_i || avs_write_i) && !pending && avs_waitrequest_o) begin
                pending           <= 1'b1;
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o    <= avs_read_i ? next_rdata : 32'h00000000;
                avs_response_o    <= hit ? 2'h0 : 2'h3;   // decode error
                if (avs_write_i && avs_byteenable_i[0]) begin
                    case (idx)
                        `SLTC_IDX_TS_CTRL:  timestamp_lsb_control <= avs_writedata_i[7:0];
                        `SLTC_IDX_SUB_EN:   link_subsystem_enable <= avs_writedata_i[7:0];
                        `SLTC_IDX_OUT_MODE: link_output_mode <= avs_writedata_i[7:0];
                        `SLTC_IDX_KM1:      multiframe_length_minus_one <= avs_writedata_i[7:0];
                        `SLTC_IDX_E_PARAM:  e_param <= avs_writedata_i[7:0];
                        default:            ;
                    endcase
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // sample path: pins synchronised, then equal-depth pipes
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ts_s1   <= 1'b0;
            ts_s2   <= 1'b0;
            sr_s1   <= 1'b0;
            sr_s2   <= 1'b0;
            sr_d    <= 1'b0;
            adc_s1  <= {ADC_BITS{1'b0}};
            adc_s2  <= {ADC_BITS{1'b0}};
            ts_pipe <= {PIPE{1'b0}};
            for (i = 0; i < PIPE; i = i + 1)
                adc_pipe[i] <= {ADC_BITS{1'b0}};
        end else begin
            ts_s1   <= timestamp_i;
            ts_s2   <= ts_s1;
            sr_s1   <= sysref_i;
            sr_s2   <= sr_s1;
            sr_d    <= sr_s2;
            adc_s1  <= adc_sample_i;
            adc_s2  <= adc_s1;
            // same depth on both paths keeps marker on its sample
            ts_pipe <= {ts_pipe[PIPE-2:0], ts_s2};
            adc_pipe[0] <= adc_s2;
            for (i = 1; i < PIPE; i = i + 1)
                adc_pipe[i] <= adc_pipe[i-1];
        end
    end

    // data above bit 0 so converter bits are never overwritten
    always @* begin
        smp = {N_BITS{1'b0}};
        smp[N_BITS-1 -: ADC_BITS] = adc_pipe[PIPE-1];
        if (timestamp_lsb_control[`SLTC_TS_EN_BIT])
            smp[0] = ts_pipe[PIPE-1];
        // 64b/66b length from E and F, F fixed at N_BITS/8 per lane
        k64_full = (`SLTC_K64_SCALE * {8'h00, e_param}) / (N_BITS / 8);
        k64 = k64_full[15:0];
        k_eff = m64 ? k64[8:0] : ({1'b0, multiframe_length_minus_one} + 9'h001);
    end

    // ---------------------------------------------------------------
    // link outputs and multiframe counter
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_sample_o           <= {N_BITS{1'b0}};
            link_reset_n_o          <= 1'b0;
            serializer_power_o      <= 1'b0;
            link_clock_enable_o     <= 1'b0;
            link_output_mode_o      <= 6'h00;
            ila_control_bits_o      <= `SLTC_ILA_CS;
            frames_per_multiframe_o <= 9'h000;
            mf_count_o              <= 9'h000;
        end else begin
            link_reset_n_o          <= en;
            serializer_power_o      <= en;
            link_clock_enable_o     <= en;
            link_output_mode_o      <= link_output_mode[`SLTC_MODE_MSB:0];
            ila_control_bits_o      <= `SLTC_ILA_CS;
            frames_per_multiframe_o <= k_eff;
            link_sample_o           <= en ? smp : {N_BITS{1'b0}};
            // counter held at zero and sysref blind while disabled
            if (!en)
                mf_count_o <= 9'h000;
            else if (sr_s2 && !sr_d)
                mf_count_o <= 9'h000;
            else if (mf_count_o + 9'h001 >= k_eff)
                mf_count_o <= 9'h000;
            else
                mf_count_o <= mf_count_o + 9'h001;
        end
    end

endmodule // sltc_link_tx_control

// ### sim/sltc_link_tx_control_properties.sv
`timescale 1ns/10ps
// ----------
// port checker
// ----------
module sltc_link_tx_control_properties #(parameter N_BITS = 16, ADC_BITS = 9, PIPE = 2) (
    // watched ports
    input wire                clk_sys_i, rst_n_i, avs_read_i, avs_write_i, timestamp_i,
    input wire                avs_waitrequest_o, link_reset_n_o, serializer_power_o,
    input wire                link_clock_enable_o,
    input wire [1:0]          avs_response_o, ila_control_bits_o,
    input wire [31:0]         avs_readdata_o,
    input wire [ADC_BITS-1:0] adc_sample_i,
    input wire [N_BITS-1:0]   link_sample_o,
    input wire [8:0]          mf_count_o
);
    localparam int LAT = PIPE + 3; // two sync stages, pipe, output flop
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // request seen while idle, not the tail of the last one
    sequence s_taken;
        (avs_read_i || avs_write_i) && avs_waitrequest_o && $past(avs_waitrequest_o);
    endsequence
    // link on long enough for the sample pipe to refill
    sequence s_on;
        link_reset_n_o && $past(link_reset_n_o, LAT);
    endsequence
    sequence s_off;
        !link_reset_n_o && !$past(link_reset_n_o);
    endsequence
    ila_zero_a: assert property (ila_control_bits_o == 2'h0)
        else $error("control bits advertised");
    enable_copy_a: assert property (serializer_power_o == link_reset_n_o
        && link_clock_enable_o == link_reset_n_o) else $error("enable copies differ");
    mf_hold_a: assert property (s_off |-> mf_count_o == 9'h000)
        else $error("multiframe counter runs while off");
    sample_off_a: assert property (s_off |-> link_sample_o == {N_BITS{1'b0}})
        else $error("samples sent while off");
    answer_next_a: assert property (s_taken |=> !avs_waitrequest_o)
        else $error("access not answered next cycle");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low two cycles");
    refuse_a: assert property (!avs_waitrequest_o && avs_response_o == 2'h3
        |-> avs_readdata_o == 32'h0) else $error("refused read returns data");
    pad_zero_a: assert property (s_on |-> link_sample_o[N_BITS-ADC_BITS-1:1] == 0)
        else $error("pad bits not zero");
    data_align_a: assert property (s_on |->
        link_sample_o[N_BITS-1 -: ADC_BITS] == $past(adc_sample_i, LAT))
        else $error("sample latency wrong");
    ts_align_a: assert property (s_on ##0 link_sample_o[0] |-> $past(timestamp_i, LAT))
        else $error("marker not aligned");
endmodule // sltc_link_tx_control_properties

bind sltc_link_tx_control sltc_link_tx_control_properties
    #(.N_BITS(N_BITS), .ADC_BITS(ADC_BITS), .PIPE(PIPE)) chk_i (.*);

// ### sim/sltc_rx_model.sv
`timescale 1ns/10ps
// ----------
// far-end receiver, counts markers on the sample lsb
// ----------
module sltc_rx_model #(parameter N_BITS = 16) (
    // link side
    input  wire              clk_sys_i,
    input  wire              link_clock_enable_i,
    input  wire [N_BITS-1:0] link_sample_i,
    // bench side
    output reg  [7:0]        marks_o
);
    initial marks_o = 8'h00;
    // gated clock means no samples arrive
    always @(posedge clk_sys_i) begin
        if (link_clock_enable_i && link_sample_i[0]) marks_o <= marks_o + 8'h01;
    end
endmodule // sltc_rx_model

// ### sim/sltc_link_tx_control_tb.sv
`timescale 1ns/10ps
module sltc_link_tx_control_tb;
    // ----------
    // stimulus and observation
    // ----------
    logic        clk_sys_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
    logic        timestamp_i = 0, sysref_i = 0;
    logic [13:0] avs_address_i = 14'h0000;
    logic [31:0] avs_writedata_i = 32'h0, q;
    logic [3:0]  avs_byteenable_i = 4'h0;
    logic [8:0]  adc_sample_i = 9'h000;
    logic [1:0]  rsp;
    wire  [31:0] avs_readdata_o;
    wire  [1:0]  avs_response_o, ila_control_bits_o;
    wire  [15:0] link_sample_o;
    wire  [5:0]  link_output_mode_o;
    wire  [8:0]  frames_per_multiframe_o, mf_count_o;
    wire  [7:0]  marks;
    wire         avs_waitrequest_o, link_reset_n_o, serializer_power_o, link_clock_enable_o;
    int          n_mismatch = 0, checked = 0;
    sltc_link_tx_control dut (.clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .avs_response_o, .adc_sample_i, .timestamp_i, .link_sample_o, .sysref_i,
        .link_reset_n_o, .serializer_power_o, .link_clock_enable_o, .link_output_mode_o,
        .ila_control_bits_o, .frames_per_multiframe_o, .mf_count_o);
    sltc_rx_model rx (.clk_sys_i, .link_clock_enable_i(link_clock_enable_o),
        .link_sample_i(link_sample_o), .marks_o(marks));
    initial forever #50 clk_sys_i = ~clk_sys_i;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one bus access; hold until waitrequest is seen low, then leave an idle edge
    task automatic acc(input logic wr, input logic [13:0] a, input logic [7:0] d);
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d}; // reserved bits always zero
        avs_byteenable_i <= 4'h1;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        // only the watchdog ends a wait that never completes
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        rsp = avs_response_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rdc(input logic [13:0] a, input logic [31:0] exp, input logic [1:0] er,
                       input string nm);
        acc(1'b0, a, 8'h00);
        chk(nm, q, exp);
        chk({nm, " response"}, 32'(rsp), 32'(er));
    endtask
    task automatic t_reset;
        rdc(14'h0580, 32'h00, 2'h0, "timestamp ctrl");
        rdc(14'h0800, 32'h01, 2'h0, "enable");
        rdc(14'h0804, 32'h00, 2'h0, "mode");
        rdc(14'h0808, 32'h1F, 2'h0, "k minus one");
        chk("k", 32'(frames_per_multiframe_o), 32'd32);
        rdc(14'h0004, 32'h00000000, 2'h3, "unmapped");
        $display("done reset values");
    endtask
    task automatic t_stamp;
        adc_sample_i <= 9'h1A5;
        timestamp_i <= 1'b1; // receiver taken as enabled
        acc(1'b1, 14'h0580, 8'h01);
        repeat (8) @(posedge clk_sys_i);
        chk("sample", 32'(link_sample_o), 32'hD281);
        chk("receiver marks", 32'(marks != 8'h00), 32'h1);
        timestamp_i <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        chk("sample", 32'(link_sample_o), 32'hD280);
        chk("control bits", 32'(ila_control_bits_o), 32'h0);
        acc(1'b1, 14'h0580, 8'h00);
        $display("done timestamp");
    endtask
    task automatic t_off;
        acc(1'b1, 14'h0800, 8'h00); // disable first
        sysref_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        sysref_i <= 1'b0;
        chk("link on", 32'({link_reset_n_o, serializer_power_o, link_clock_enable_o}), 0);
        chk("mf count", 32'(mf_count_o), 32'h0);
        acc(1'b1, 14'h0808, 8'h0F); // legal k for mode 0
        acc(1'b1, 14'h0804, 8'h3F);
        rdc(14'h0804, 32'h3F, 2'h0, "mode");
        chk("mode out", 32'(link_output_mode_o), 32'h3F);
        acc(1'b1, 14'h0804, 8'h00);
        acc(1'b1, 14'h0800, 8'h01);
        chk("k", 32'(frames_per_multiframe_o), 32'd16);
        chk("link on", 32'({link_reset_n_o, serializer_power_o, link_clock_enable_o}), 7);
        acc(1'b1, 14'h0800, 8'h00);
        acc(1'b1, 14'h0804, 8'h20);
        acc(1'b1, 14'h0800, 8'h01);
        chk("k 64b", 32'(frames_per_multiframe_o), 32'd128);
        // sysref edge while enabled realigns the counter, then it counts up
        sysref_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        chk("mf align", 32'(mf_count_o), 32'h0);
        sysref_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        chk("mf run", 32'(mf_count_o), 32'h5);
        $display("done disable and modes");
    endtask
    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        t_reset;
        t_stamp;
        t_off;
        conclude;
    end
    // run needs about 85 cycles; the 5000-cycle watchdog is ample
    initial begin
        #500000;
        n_mismatch++;
        conclude;
    end
endmodule // sltc_link_tx_control_tb
